// ==== inc/loudness_pkg.sv ====
package loudness_pkg;

  // sample rate and gating geometry
  localparam int  RATE_HZ       = 48000;
  localparam int  BLOCK_MS      = 400;
  localparam int  BLOCK_SAMPLES = (RATE_HZ * BLOCK_MS + 500) / 1000; // nearest whole sample
  localparam int  QUARTERS      = 4;                                 // 75 % overlap, step of a quarter
  localparam int  BLOCK_DEPTH   = 1024;                              // stored blocks per measurement

  // data widths
  localparam int  NUM_CH        = 5;
  localparam int  SAMPLE_W      = 24;
  localparam int  GUARD_W       = 8;
  localparam int  FILT_W        = 40;
  localparam int  ENERGY_W      = 64;
  localparam int  TOTAL_W       = 80;
  localparam int  LOUD_W        = 20;
  localparam int  DB_FRAC       = 8;
  localparam int  COEF_FRAC     = 28;
  localparam int  WEIGHT_FRAC   = 8;

  // head shelving stage at 48 kHz
  localparam real SHELF_B0      = 1.53512485958697;
  localparam real SHELF_B1      = -2.69169618940638;
  localparam real SHELF_B2      = 1.19839281085285;
  localparam real SHELF_A1      = -1.69065929318241;
  localparam real SHELF_A2      = 0.73248077421585;

  // high-pass stage at 48 kHz
  localparam real HPASS_B0      = 1.0;
  localparam real HPASS_B1      = -2.0;
  localparam real HPASS_B2      = 1.0;
  localparam real HPASS_A1      = -1.99004745483398;
  localparam real HPASS_A2      = 0.99007225036621;

  // channel weights, offset and gate levels
  localparam real GAIN_FRONT    = 1.0;
  localparam real GAIN_REAR     = 1.41;
  localparam real OFFSET_DB     = -0.691;
  localparam real ABS_GATE_DB   = -70.0;
  localparam int  REL_FACTOR    = 10;      // -10 dB relative gate as a power ratio
  localparam real LOG_CORR      = 0.346607; // mantissa bend of the log2 estimate

endpackage

// ==== testbench/audio_source.sv ====
`timescale 1ns/100ps
`default_nettype none
module audio_source (
  input  wire logic                                clock_i,
  input  wire logic [2:0]                          ch_i,
  input  var  real                                 amp_i,
  input  var  int                                  stop_i,
  output logic                                     valid_o,
  output logic signed [loudness_pkg::SAMPLE_W-1:0] chan_o [5],
  output int                                       count_o
);
  // quiet lines at time zero
  initial begin
    valid_o = 1'h0;
    count_o = 0;
    foreach (chan_o[i]) chan_o[i] = '0;
  end
  // 997 Hz tone, a sample every second falling edge; the active line shows inverted data between samples
  always @(negedge clock_i) begin
    valid_o <= (count_o < stop_i) && !valid_o;
    for (int i = 0; i < 5; i++) begin
      chan_o[i] <= (i == ch_i) ? ~chan_o[i] : '0; // unused inputs at zero
    end
    if ((count_o < stop_i) && !valid_o) begin
      chan_o[ch_i] <= 24'($rtoi(amp_i * 8388607.0 * $sin(6.283185307 * 997.0 * count_o / 48000.0)));
      count_o <= count_o + 1;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/loudness_meter_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module loudness_meter_test;
  localparam int BL = 480;
  localparam int QL = BL / 4;
  localparam int DP = 16;
  logic                                   clock_i = 1'h0;
  logic                                   sys_rst_i = 1'h1;
  logic                                   meas_start_i = 1'h0;
  logic                                   meas_end_i = 1'h0;
  logic                                   sample_valid_i;
  logic signed [loudness_pkg::SAMPLE_W-1:0] chan [5];
  logic [2:0]                             ch = 3'h0;
  real                                    amp = 0.0;
  int                                     stop = 0;
  int                                     cnt;
  logic                                   busy_o, block_valid_o, block_pass_o;
  logic                                   overflow_o, result_valid_o, gated_empty_o;
  logic signed [loudness_pkg::LOUD_W-1:0] block_loud_o, gated_loud_o, ungated_loud_o;
  int                                     err_total = 0, total_checks = 0, nblk = 0, npass = 0;
  real                                    qp[$];
  ////////////////////////////////////////////////////////////
  // clock, source and meter
  always #12.5 clock_i = ~clock_i;
  audio_source u_audio_source (.clock_i(clock_i), .ch_i(ch), .amp_i(amp), .stop_i(stop),
    .valid_o(sample_valid_i), .chan_o(chan), .count_o(cnt));
  loudness_meter #(.BLOCK_LEN(BL), .DEPTH(DP)) u_loudness_meter (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .meas_start_i(meas_start_i), .meas_end_i(meas_end_i),
    .sample_valid_i(sample_valid_i), .left_i(chan[0]), .right_i(chan[1]), .centre_i(chan[2]),
    .left_rear_channel_i(chan[3]), .right_rear_channel_i(chan[4]), .busy_o(busy_o),
    .block_valid_o(block_valid_o), .block_loud_o(block_loud_o), .block_pass_o(block_pass_o),
    .overflow_o(overflow_o), .result_valid_o(result_valid_o), .gated_loud_o(gated_loud_o),
    .ungated_loud_o(ungated_loud_o), .gated_empty_o(gated_empty_o));
  // count blocks and absolute-gate passes
  always @(negedge clock_i) begin
    if (block_valid_o === 1'h1) begin
      nblk++;
      npass += (block_pass_o === 1'h1);
    end
  end
  ////////////////////////////////////////////////////////////
  // reference helpers; level relative to a full-scale front tone
  function automatic real lk(input real p);
    return -3.01 + 10.0 * $log10(p + 1.0e-12);
  endfunction
  function automatic real bpow(input int j);
    return (qp[j] + qp[j+1] + qp[j+2] + qp[j+3]) / 4.0;
  endfunction
  function automatic logic near(input logic signed [loudness_pkg::LOUD_W-1:0] v, input int e);
    return (v >= e - 51) && (v <= e + 51);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: saw %0d, wanted %0d", $time, seen, want);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic guard(input logic ok);
    if (ok !== 1'h1) begin
      err_total++;
      $display("unexpected at %0t: wait ran out", $time);
      print_verdict();
    end
  endtask
  ////////////////////////////////////////////////////////////
  // measurement steps shared by the scenarios
  task automatic begin_meas();
    meas_start_i <= 1'h1;
    @(negedge clock_i);
    meas_start_i <= 1'h0;
    @(negedge clock_i);
    qp.delete();
    nblk = 0;
    npass = 0;
    check(busy_o, 1);
  endtask
  task automatic feed(input logic [2:0] c, input real a, input int nq, input int extra);
    int t;
    int i = 0;
    t = cnt + nq * QL + extra;
    ch <= c;
    amp <= a;
    stop <= t;
    while (cnt < t && i < 4 * (nq * QL + extra) + 8) begin
      @(negedge clock_i);
      i++;
    end
    guard(cnt >= t);
    repeat (nq) qp.push_back(a * a * ((c > 2) ? 1.41 : 1.0));
  endtask
  task automatic finish_meas();
    real s1 = 0.0, s2 = 0.0, sa = 0.0, thr;
    int n1 = 0, n2 = 0, np = 0, k = 1, lim;
    int nb = qp.size() - 3;
    repeat (8) @(negedge clock_i);
    meas_end_i <= 1'h1;
    @(negedge clock_i);
    meas_end_i <= 1'h0;
    while (result_valid_o !== 1'h1 && k < 200) begin
      @(negedge clock_i);
      k++;
    end
    guard(k < 200);
    foreach (qp[q]) sa += qp[q];
    lim = (nb < DP) ? nb : DP;
    for (int j = 0; j < nb; j++) begin
      if (lk(bpow(j)) > -70.0) begin
        np++;
        s1 += (j < DP) ? bpow(j) : 0.0;
        n1 += (j < DP);
      end
    end
    thr = lk(s1 / ((n1 > 0) ? n1 : 1)) - 10.0;
    for (int j = 0; j < lim; j++) begin
      if (lk(bpow(j)) > -70.0 && lk(bpow(j)) > thr) begin
        s2 += bpow(j);
        n2++;
      end
    end
    check(k, (lim > 0) ? 2 * lim + 5 : 5);
    check(busy_o, 0);
    check(nblk, nb);
    check(npass, np);
    if (nb > 0 && lk(bpow(nb - 1)) > -70.0) check(near(block_loud_o, $rtoi(256.0 * lk(bpow(nb - 1)))), 1);
    check(overflow_o, nb > DP);
    check(gated_empty_o, n2 == 0);
    if (n2 > 0) begin
      check(near(gated_loud_o, $rtoi(256.0 * lk(s2 / n2))), 1);
      check(near(ungated_loud_o, $rtoi(256.0 * lk(sa / qp.size()))), 1);
    end
  endtask
  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_front();
    begin_meas();
    feed(3'h0, 1.0, 24, 0);
    finish_meas();
    check(near(gated_loud_o, -771), 1);
  endtask
  task automatic t_rear();
    begin_meas();
    feed(3'h4, 1.0, 8, 0);
    finish_meas();
    check(near(gated_loud_o, -389), 1);
  endtask
  task automatic t_level();
    begin_meas();
    feed(3'h2, 0.5, 8, 0);
    finish_meas();
    check(near(gated_loud_o, -2312), 1);
  endtask
  task automatic t_gate();
    begin_meas();
    feed(3'h1, 1.0, 8, 0);
    feed(3'h1, 0.01, 12, 0);
    finish_meas();
  endtask
  task automatic t_tail();
    begin_meas();
    feed(3'h3, 0.0, 8, 0);
    feed(3'h0, 1.0, 0, 60);
    finish_meas();
    check(gated_empty_o, 1);
  endtask
  task automatic t_restart();
    begin_meas();
    feed(3'h0, 1.0, 6, 0);
    begin_meas();
    feed(3'h2, 0.1, 8, 0);
    finish_meas();
    check(near(gated_loud_o, -5891), 1);
  endtask
  // reset, then each scenario in turn
  initial begin
    repeat (5) @(negedge clock_i);
    sys_rst_i <= 1'h0;
    @(negedge clock_i);
    t_front();
    t_rear();
    t_level();
    t_gate();
    t_tail();
    t_restart();
    print_verdict();
  end
endmodule
`default_nettype wire

// ==== verilog/k_biquad.sv ====
`timescale 1ns/100ps
`default_nettype none
module k_biquad #(
  parameter int  SW = loudness_pkg::FILT_W,
  parameter real B0 = 1.0,
  parameter real B1 = 0.0,
  parameter real B2 = 0.0,
  parameter real A1 = 0.0,
  parameter real A2 = 0.0
) (
  input  wire logic                 clock_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 clear_i,
  input  wire logic                 en_i,
  input  wire logic signed [SW-1:0] x_i,
  output logic signed      [SW-1:0] y_o,
  output logic                      valid_o
);

  localparam int FR  = loudness_pkg::COEF_FRAC;
  localparam int AW  = SW + 36;
  localparam int QB0 = int'(B0 * (2.0 ** FR));
  localparam int QB1 = int'(B1 * (2.0 ** FR));
  localparam int QB2 = int'(B2 * (2.0 ** FR));
  localparam int QA1 = int'(A1 * (2.0 ** FR));
  localparam int QA2 = int'(A2 * (2.0 ** FR));

  logic signed [SW-1:0] x1_q;
  logic signed [SW-1:0] x2_q;
  logic signed [SW-1:0] y2_q;
  logic signed [AW-1:0] acc;

  // direct form one, a0 taken as one
  always_comb begin
    acc = AW'(x_i) * AW'(QB0) + AW'(x1_q) * AW'(QB1) + AW'(x2_q) * AW'(QB2)
        - AW'(y_o) * AW'(QA1) - AW'(y2_q) * AW'(QA2);
  end

  // history shifts once per accepted sample
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || clear_i) begin
      x1_q    <= '0;
      x2_q    <= '0;
      y_o     <= '0;
      y2_q    <= '0;
      valid_o <= 1'b0;
    end else begin
      valid_o <= en_i;
      if (en_i) begin
        x1_q <= x_i;
        x2_q <= x1_q;
        y_o  <= SW'(acc >>> FR);
        y2_q <= y_o;
      end
    end
  end

endmodule
`default_nettype wire

// ==== verilog/log_db.sv ====
`timescale 1ns/100ps
`default_nettype none
module log_db #(
  parameter int IW = loudness_pkg::TOTAL_W,
  parameter int OW = loudness_pkg::LOUD_W
) (
  input  wire logic        [IW-1:0] x_i,
  output logic signed      [OW-1:0] db_o
);

  localparam int     FB     = 16;
  localparam int     PW     = $clog2(IW);
  localparam longint K_DB   = longint'(10.0 * $log10(2.0) * (2.0 ** FB));
  localparam longint K_CORR = longint'(loudness_pkg::LOG_CORR * (2.0 ** FB));

  logic [PW-1:0]   pos;
  logic [IW-1:0]   norm;
  logic [FB-1:0]   frac;
  logic [2*FB-1:0] bend;
  logic [47:0]     l2;
  logic [79:0]     prod;

  // leading one, mantissa bend, then scale log2 to tenths of a bel
  always_comb begin
    pos = '0;
    for (int i = 0; i < IW; i++) begin
      if (x_i[i]) begin
        pos = PW'(i);
      end
    end
    norm = x_i << (IW - 1 - int'(pos));
    frac = norm[IW-2 -: FB];
    bend = (2*FB)'(frac) * ((2*FB)'(1 << FB) - (2*FB)'(frac));
    l2   = (48'(pos) << FB) + 48'(frac) + 48'((64'(bend >> FB) * 64'(K_CORR)) >> FB);
    prod = 80'(l2) * 80'(K_DB);
    if (x_i == '0) begin
      db_o = {1'b1, {(OW-1){1'b0}}}; // silence reads as most negative
    end else begin
      db_o = OW'(prod >> (2 * FB - loudness_pkg::DB_FRAC));
    end
  end

endmodule
`default_nettype wire

// ==== verilog/loudness_meter.sv ====
`timescale 1ns/100ps
`default_nettype none
// Function
// [RL1] shelf stage then high-pass stage per channel
// [RL2] shelf feed-forward coefficients as given
// [RL3] shelf feedback coefficients as given
// [RL4] high-pass feedback coefficients as given
// [RL5] high-pass feed-forward is one, minus two, one
// [RL6] coefficients hold for 48 kHz only
// [RL7] coefficients quantised to internal precision
// [RL8] mean square of filtered samples per channel
// [RL9] five main inputs, no effects channel
// [RL10] idle inputs held at zero add nothing
// [RL11] weights one front, 1.41 rear
// [RL12] ungated loudness: offset plus ten log sum
// [RL13] gating blocks of 400 ms samples
// [RL14] blocks overlap 75 percent, quarter step
// [RL15] interval ends on block boundary, partials dropped
// [RL16] block loudness with same offset and weights
// [RL17] keep blocks strictly above absolute gate
// [RL18] relative gate is absolute-gated loudness minus ten
// [RL19] average survivors, weight, sum, take log
// [RL20] reading moves one unit per dB; the code moves 256 units per dB (DB_FRAC = 8 fraction bits)
// [RL21] full-scale front sine reads minus 3.01
// [RL22] biquad with a0 normalised to one
// [RL23] start clears filters and accumulators
module loudness_meter #(
  parameter int BLOCK_LEN = loudness_pkg::BLOCK_SAMPLES,
  parameter int DEPTH     = loudness_pkg::BLOCK_DEPTH
) (
  input  wire logic                                      clock_i,
  input  wire logic                                      sys_rst_i,
  input  wire logic                                      meas_start_i,
  input  wire logic                                      meas_end_i,
  input  wire logic                                      sample_valid_i,
  input  wire logic signed [loudness_pkg::SAMPLE_W-1:0]  left_i,
  input  wire logic signed [loudness_pkg::SAMPLE_W-1:0]  right_i,
  input  wire logic signed [loudness_pkg::SAMPLE_W-1:0]  centre_i,
  input  wire logic signed [loudness_pkg::SAMPLE_W-1:0]  left_rear_channel_i,
  input  wire logic signed [loudness_pkg::SAMPLE_W-1:0]  right_rear_channel_i,
  output logic                                           busy_o,
  output logic                                           block_valid_o,
  output logic signed      [loudness_pkg::LOUD_W-1:0]    block_loud_o,
  output logic                                           block_pass_o,
  output logic                                           overflow_o,
  output logic                                           result_valid_o,
  output logic signed      [loudness_pkg::LOUD_W-1:0]    gated_loud_o,
  output logic signed      [loudness_pkg::LOUD_W-1:0]    ungated_loud_o,
  output logic                                           gated_empty_o
);

  localparam int NCH  = loudness_pkg::NUM_CH;
  localparam int DW   = loudness_pkg::SAMPLE_W;
  localparam int SW   = loudness_pkg::FILT_W;
  localparam int EW   = loudness_pkg::ENERGY_W;
  localparam int TW   = loudness_pkg::TOTAL_W;
  localparam int OW   = loudness_pkg::LOUD_W;
  localparam int NQ   = loudness_pkg::QUARTERS;
  localparam int QLEN = BLOCK_LEN / NQ;
  localparam int QCW  = $clog2(QLEN + 1);
  localparam int BCW  = $clog2(DEPTH + 1);
  localparam int NQW  = 24;
  // full-scale weighted power sits at two to this power
  localparam int PFRAC = 2 * (DW - 1 + loudness_pkg::GUARD_W) - 2 * (SW - DW)
                       + loudness_pkg::WEIGHT_FRAC;
  localparam real SCALE_DB = 10.0 * $log10(2.0) * PFRAC;
  localparam int OFS_B = int'((loudness_pkg::OFFSET_DB - 10.0 * $log10(real'(BLOCK_LEN)) - SCALE_DB)
                              * (2.0 ** loudness_pkg::DB_FRAC));
  localparam int OFS_Q = int'((loudness_pkg::OFFSET_DB - 10.0 * $log10(real'(QLEN)) - SCALE_DB)
                              * (2.0 ** loudness_pkg::DB_FRAC));
  localparam int ABS_Q = int'(loudness_pkg::ABS_GATE_DB * (2.0 ** loudness_pkg::DB_FRAC));
  localparam logic [9:0] G_FRONT = 10'(int'(loudness_pkg::GAIN_FRONT * (2.0 ** loudness_pkg::WEIGHT_FRAC)));
  localparam logic [9:0] G_REAR  = 10'(int'(loudness_pkg::GAIN_REAR * (2.0 ** loudness_pkg::WEIGHT_FRAC)));

  typedef enum logic [2:0] {
    ST_IDLE, ST_RUN, ST_PASS1, ST_PASS2, ST_LOG_G, ST_LOG_GN, ST_LOG_U, ST_LOG_UN
  } meter_state_t;

  meter_state_t         state_q;
  logic signed [DW-1:0] ch_x   [NCH];
  logic signed [SW-1:0] y1     [NCH];
  logic signed [SW-1:0] y2     [NCH];
  logic                 s1_vld [NCH];
  logic                 s2_vld [NCH];
  logic [EW-1:0]        pwr_d;
  logic [EW-1:0]        pwr_q;
  logic                 p_vld_q;
  logic [EW-1:0]        qacc_q;
  logic [QCW-1:0]       qcnt_q;
  logic                 qdone_q;
  logic [EW-1:0]        q_hist_q [NQ];
  logic [NQW-1:0]       nq_q;
  logic [TW-1:0]        total_q;
  logic [EW-1:0]        blk_e;
  logic                 blk_wr;
  logic signed [OW-1:0] blk_l;
  logic [EW:0]          blk_mem [DEPTH];
  logic [BCW-1:0]       nblk_q;
  logic [BCW-1:0]       idx_q;
  logic [EW:0]          rd_word;
  logic                 rel_ok;
  logic [TW-1:0]        sum1_q;
  logic [TW-1:0]        sum2_q;
  logic [BCW-1:0]       cnt1_q;
  logic [BCW-1:0]       cnt2_q;
  logic [TW-1:0]        log_in;
  logic signed [OW-1:0] db_val;
  logic signed [OW-1:0] lg_a_q;

  // channel weight per input slot
  function automatic logic [9:0] gain_of(input int c);
    gain_of = (c >= 3) ? G_REAR : G_FRONT; // [RL11]
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pre-filter, two stages per channel

  // only the five main inputs exist; unused ones must be driven at zero
  assign ch_x[0] = left_i;               // [RL9]
  assign ch_x[1] = right_i;
  assign ch_x[2] = centre_i;
  assign ch_x[3] = left_rear_channel_i;
  assign ch_x[4] = right_rear_channel_i; // [RL10]

  // shelf feeds high-pass, both cleared at measurement start
  for (genvar c = 0; c < NCH; c++) begin : g_chan
    k_biquad #(
      .SW (SW),
      .B0 (loudness_pkg::SHELF_B0),
      .B1 (loudness_pkg::SHELF_B1),
      .B2 (loudness_pkg::SHELF_B2),
      .A1 (loudness_pkg::SHELF_A1),
      .A2 (loudness_pkg::SHELF_A2)
    ) u_shelf (                                   // [RL1] [RL2] [RL3] [RL7] [RL22]
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .clear_i   (meas_start_i),                  // [RL23]
      .en_i      (sample_valid_i),
      .x_i       (SW'($signed({ch_x[c], {loudness_pkg::GUARD_W{1'b0}}}))),
      .y_o       (y1[c]),
      .valid_o   (s1_vld[c])
    );
    k_biquad #(
      .SW (SW),
      .B0 (loudness_pkg::HPASS_B0),
      .B1 (loudness_pkg::HPASS_B1),
      .B2 (loudness_pkg::HPASS_B2),
      .A1 (loudness_pkg::HPASS_A1),
      .A2 (loudness_pkg::HPASS_A2)
    ) u_hpass (                                   // [RL1] [RL4] [RL5] [RL6] [RL22]
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .clear_i   (meas_start_i),                  // [RL23]
      .en_i      (s1_vld[c]),
      .x_i       (y1[c]),
      .y_o       (y2[c]),
      .valid_o   (s2_vld[c])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // weighted square per sample

  // squares scaled by channel gain and summed
  always_comb begin
    logic signed [2*DW-1:0] sq;
    sq    = '0;
    pwr_d = '0;
    for (int c = 0; c < NCH; c++) begin
      sq    = $signed(y2[c][SW-1:SW-DW]) * $signed(y2[c][SW-1:SW-DW]); // [RL8]
      pwr_d = pwr_d + EW'($unsigned(sq)) * EW'(gain_of(c));     // [RL11]
    end
  end

  // register power with its strobe
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || meas_start_i) begin
      pwr_q   <= '0;
      p_vld_q <= 1'b0;
    end else begin
      pwr_q   <= pwr_d;
      p_vld_q <= s2_vld[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // quarter sums and running total

  // a quarter closes every QLEN samples; partial quarters never count
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || meas_start_i) begin
      qacc_q  <= '0;
      qcnt_q  <= '0;
      qdone_q <= 1'b0;
      nq_q    <= '0;
      total_q <= '0;
      for (int k = 0; k < NQ; k++) begin
        q_hist_q[k] <= '0;
      end
    end else begin
      qdone_q <= 1'b0;
      if (state_q == ST_RUN && p_vld_q) begin
        if (qcnt_q == QCW'(QLEN - 1)) begin                      // [RL13] [RL14]
          qacc_q      <= '0;
          qcnt_q      <= '0;
          qdone_q     <= 1'b1;
          nq_q        <= nq_q + 1'b1;
          total_q     <= total_q + TW'(qacc_q + pwr_q);          // [RL15]
          q_hist_q[0] <= qacc_q + pwr_q;
          for (int k = 1; k < NQ; k++) begin
            q_hist_q[k] <= q_hist_q[k-1];
          end
        end else begin
          qacc_q <= qacc_q + pwr_q;
          qcnt_q <= qcnt_q + 1'b1;
        end
      end
    end
  end

  // block energy is the last four quarters
  always_comb begin
    blk_e = '0;
    for (int k = 0; k < NQ; k++) begin
      blk_e = blk_e + q_hist_q[k];                               // [RL14]
    end
  end

  assign blk_wr = qdone_q && (nq_q >= NQW'(NQ));                 // [RL15]
  // a silent block reads most negative instead of wrapping
  assign blk_l  = (blk_e == '0) ? {1'b1, {(OW-1){1'b0}}} : OW'(int'(db_val) + OFS_B); // [RL16] [RL20]

  //////////////////////////////////////////////////////////////////////////////
  // block store and per-block report

  // block loudness, absolute gate flag and write count
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || meas_start_i) begin
      block_valid_o <= 1'b0;
      block_loud_o  <= '0;
      block_pass_o  <= 1'b0;
      nblk_q        <= '0;
      overflow_o    <= 1'b0;
    end else begin
      block_valid_o <= blk_wr;
      if (blk_wr) begin
        block_loud_o <= blk_l;
        block_pass_o <= (int'(blk_l) > ABS_Q);                   // [RL17]
        if (nblk_q < BCW'(DEPTH)) begin
          nblk_q <= nblk_q + 1'b1;
        end else begin
          overflow_o <= 1'b1;
        end
      end
    end
  end

  // energy and gate flag of each of the first DEPTH blocks
  always_ff @(posedge clock_i) begin
    if (blk_wr && nblk_q < BCW'(DEPTH)) begin
      blk_mem[nblk_q[BCW-2:0]] <= {(int'(blk_l) > ABS_Q), blk_e}; // [RL17]
    end
  end

  assign rd_word = blk_mem[idx_q[BCW-2:0]];
  // above -10 dB of the absolute-gated mean, kept division free
  assign rel_ok  = rd_word[EW] && (TW'(rd_word[EW-1:0]) * TW'(loudness_pkg::REL_FACTOR) * TW'(cnt1_q)
                                   > sum1_q);                    // [RL18]

  //////////////////////////////////////////////////////////////////////////////
  // shared log converter

  // one converter, used by blocks while running and by the final steps
  always_comb begin
    case (state_q)
      ST_LOG_G:  log_in = sum2_q;
      ST_LOG_GN: log_in = TW'(cnt2_q);
      ST_LOG_U:  log_in = total_q;
      ST_LOG_UN: log_in = TW'(nq_q);
      default:   log_in = TW'(blk_e);
    endcase
  end

  log_db #(
    .IW (TW),
    .OW (OW)
  ) u_log (
    .x_i  (log_in),
    .db_o (db_val)
  );

  //////////////////////////////////////////////////////////////////////////////
  // measurement sequence

  // run, two gating sweeps, then four log steps
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_q        <= ST_IDLE;
      idx_q          <= '0;
      sum1_q         <= '0;
      sum2_q         <= '0;
      cnt1_q         <= '0;
      cnt2_q         <= '0;
      lg_a_q         <= '0;
      gated_loud_o   <= '0;
      ungated_loud_o <= '0;
      gated_empty_o  <= 1'b0;
      result_valid_o <= 1'b0;
    end else if (meas_start_i) begin
      state_q        <= ST_RUN;                                  // [RL23]
      idx_q          <= '0;
      sum1_q         <= '0;
      sum2_q         <= '0;
      cnt1_q         <= '0;
      cnt2_q         <= '0;
      result_valid_o <= 1'b0;
    end else begin
      result_valid_o <= 1'b0;
      case (state_q)
        ST_RUN: begin
          if (meas_end_i) begin
            state_q <= (nblk_q == '0 && !blk_wr) ? ST_LOG_G : ST_PASS1;
          end
        end
        ST_PASS1: begin
          if (rd_word[EW]) begin
            sum1_q <= sum1_q + TW'(rd_word[EW-1:0]);             // [RL17]
            cnt1_q <= cnt1_q + 1'b1;
          end
          idx_q   <= (idx_q == nblk_q - 1'b1) ? '0 : idx_q + 1'b1;
          state_q <= (idx_q == nblk_q - 1'b1) ? ST_PASS2 : ST_PASS1;
        end
        ST_PASS2: begin
          if (rel_ok) begin
            sum2_q <= sum2_q + TW'(rd_word[EW-1:0]);             // [RL19]
            cnt2_q <= cnt2_q + 1'b1;
          end
          idx_q   <= (idx_q == nblk_q - 1'b1) ? '0 : idx_q + 1'b1;
          state_q <= (idx_q == nblk_q - 1'b1) ? ST_LOG_G : ST_PASS2;
        end
        ST_LOG_G: begin
          lg_a_q  <= db_val;
          state_q <= ST_LOG_GN;
        end
        ST_LOG_GN: begin
          gated_loud_o  <= OW'(int'(lg_a_q) - int'(db_val) + OFS_B); // [RL19] [RL21]
          gated_empty_o <= (cnt2_q == '0);
          state_q       <= ST_LOG_U;
        end
        ST_LOG_U: begin
          lg_a_q  <= db_val;
          state_q <= ST_LOG_UN;
        end
        ST_LOG_UN: begin
          ungated_loud_o <= (total_q == '0) ? {1'b1, {(OW-1){1'b0}}}
                                            : OW'(int'(lg_a_q) - int'(db_val) + OFS_Q); // [RL12]
          result_valid_o <= 1'b1;
          state_q        <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign busy_o = (state_q != ST_IDLE);

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  a_stage_order: assert property (s1_vld[0] && !meas_start_i |=> s2_vld[0]) // [RL1]
    else $error("high-pass stage did not follow shelf stage");

  a_start_clear: assert property (meas_start_i |=> nq_q == '0 && nblk_q == '0 && state_q == ST_RUN) // [RL23]
    else $error("measurement start did not clear state");

  a_quarter_len: assert property (qdone_q && !$past(meas_start_i) |-> $past(qcnt_q) == QCW'(QLEN - 1)) // [RL13]
    else $error("quarter closed at wrong sample count");

  a_full_blocks: assert property (block_valid_o |-> $past(nq_q) >= NQW'(NQ)) // [RL15]
    else $error("block reported before four quarters");

  a_abs_gate: assert property (block_valid_o |-> block_pass_o == (int'(block_loud_o) > ABS_Q)) // [RL17]
    else $error("absolute gate flag wrong");

  a_rel_subset: assert property (state_q == ST_PASS2 && rel_ok && !meas_start_i
                                 |=> cnt2_q == $past(cnt2_q) + 1'b1) // [RL18]
    else $error("relative gate survivor not counted");

  a_gated_steps: assert property (result_valid_o |-> $past(state_q, 1) == ST_LOG_UN
                                  && $past(state_q, 3) == ST_LOG_GN) // [RL19]
    else $error("result not built from gated sums");

  a_ungated_hold: assert property (result_valid_o |=> !result_valid_o && state_q != ST_LOG_UN) // [RL12]
    else $error("result strobe longer than one cycle");

  a_no_early_blk: assert property (p_vld_q && !meas_start_i |-> ##1 !block_valid_o) // [RL14]
    else $error("block reported on non-boundary sample");

  c_block_seen:  cover property (block_valid_o && block_pass_o);
  c_block_quiet: cover property (block_valid_o && !block_pass_o);
  c_result:      cover property (result_valid_o && !gated_empty_o);
  c_empty:       cover property (result_valid_o && gated_empty_o);

endmodule
`default_nettype wire
